//--- dv/test_wakeup_timer_measure_regs.sv
// bench for the wake-up timer and measurement register block
// assumes shortened timer bases of 40 and 10 cycles
`timescale 1ns/1ns
module test_wakeup_timer_measure_regs;
  import wut_pkg::*;
  logic i_sys_clk, i_srst, i_wr, i_rd, i_wakeup_mode, i_set_default, i_cal_done, i_cal_error;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_amp_result, aux, pc_cfg;
  logic [2:0] o_meas_start, i_meas_done, o_excursion_irq;
  logic o_timeout_irq, o_wakeup_irq;
  logic [4:0] i_cal_value;
  int err_total = 0;
  int n_checks = 0;
  wakeup_timer_measure_regs #(.LONG_BASE_CYCLES_P(40), .SHORT_BASE_CYCLES_P(10)) i_dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_wakeup_mode(i_wakeup_mode),
    .i_set_default(i_set_default), .o_meas_start(o_meas_start), .i_meas_done(i_meas_done),
    .i_amp_result(i_amp_result), .i_phase_result(i_amp_result), .i_cap_result(i_amp_result),
    .i_phase_config(pc_cfg), .i_phase_reference(8'h00), .i_cap_config(pc_cfg),
    .i_cap_reference(8'h00), .o_timeout_irq(o_timeout_irq), .o_excursion_irq(o_excursion_irq),
    .o_wakeup_irq(o_wakeup_irq), .i_cal_done(i_cal_done), .i_cal_error(i_cal_error),
    .i_cal_value(i_cal_value), .i_rx_channel_pm(aux[7]), .i_field_detected(aux[6]),
    .i_tx_active(aux[5]), .i_osc_stable(aux[4]), .i_rx_enabled(aux[3]),
    .i_rx_receiving(aux[2]), .i_field_detect_peer(aux[1]),
    .i_field_detect_collision_avoid(aux[0]));
  // ****************************************
  // clock and shared tasks
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one-cycle write, then one-cycle read sampled in the following cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_sys_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_sys_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_sys_clk) i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] d;
    for (int a = 'h2F; a <= 'h33; a++) begin
      rd(a[5:0], d);
      check(d, 8'h00);
    end
    wr(ADDR_AMP_REFERENCE, 8'hA7);
    wr(ADDR_AUX_DISPLAY, 8'hFF);
    rd(ADDR_AMP_REFERENCE, d);
    check(d, 8'hA7);
    rd(ADDR_AUX_DISPLAY, d);
    check(d, 8'h00);
    rd(6'h3F, d);
    check(d, 8'h00);
    $display("regs done");
  endtask
  task automatic t_status;
    logic [7:0] d;
    @(posedge i_sys_clk) aux <= 8'hA5;
    @(posedge i_sys_clk) {i_cal_done, i_cal_value, i_cal_error} <= {1'b1, 5'h15, 1'b1};
    @(posedge i_sys_clk) i_cal_done <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    rd(ADDR_AUX_DISPLAY, d);
    check(d, 8'hA5);
    rd(ADDR_CAPSENSE_DISPLAY, d);
    check(d, 8'hAE);
    $display("status done");
  endtask
  // period between two successive expiries, with outputs seen at expiry
  task automatic t_timer(input logic [7:0] ctl, input int exp);
    int n;
    wr(ADDR_TIMER_CTRL, ctl);
    i_wakeup_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge i_sys_clk) #1 n++;
      end while (o_timeout_irq !== 1'b1 && n < 500);
    end
    check(n[7:0], exp[7:0]);
    check({o_meas_start, o_timeout_irq, o_wakeup_irq}, {3'b0, ctl[2:0], 2'b11});
    @(posedge i_sys_clk) i_wakeup_mode <= 1'b0;
    $display("timer done");
  endtask
  // one result on the kinds in m; collect irq bits and count pulse cycles after it
  task automatic t_exc(input logic [2:0] m, input logic [7:0] res, input logic [3:0] exp);
    int n = 0;
    logic [3:0] s = 4'h0;
    @(posedge i_sys_clk) {i_meas_done, i_amp_result} <= {m, res};
    @(posedge i_sys_clk) i_meas_done <= 3'b000;
    repeat (4) begin
      @(posedge i_sys_clk) #1 n += (o_excursion_irq !== 3'b000);
      s |= {o_excursion_irq, o_wakeup_irq};
    end
    check({4'h0, s}, {4'h0, exp});
    check(n[7:0], {7'h00, |exp});
  endtask
  task automatic t_meas;
    logic [7:0] d;
    wr(ADDR_TIMER_CTRL, 8'h04);
    wr(ADDR_AMP_REFERENCE, 8'h40);
    wr(ADDR_AMP_CONFIG, 8'h30);
    pc_cfg <= 8'h30;
    t_exc(3'b100, 8'h43, 4'h0);
    t_exc(3'b100, 8'h44, 4'h9);
    t_exc(3'b100, 8'h3C, 4'h9);
    rd(ADDR_AMP_AVG_DISPLAY, d);
    check(d, 8'h10);
    rd(ADDR_AMP_RESULT_DISPLAY, d);
    check(d, 8'h3C);
    t_exc(3'b010, 8'h44, 4'h0);
    wr(ADDR_TIMER_CTRL, 8'h03);
    t_exc(3'b011, 8'h44, 4'h7);
    wr(ADDR_TIMER_CTRL, 8'h04);
    wr(ADDR_AMP_CONFIG, 8'h31);
    t_exc(3'b100, 8'h12, 4'h0);
    @(posedge i_sys_clk) i_set_default <= 1'b1;
    @(posedge i_sys_clk) i_set_default <= 1'b0;
    rd(ADDR_AMP_CONFIG, d);
    check(d, 8'h00);
    rd(ADDR_AMP_REFERENCE, d);
    check(d, 8'h00);
    rd(ADDR_CAPSENSE_DISPLAY, d);
    check(d, 8'h00);
    wr(ADDR_AMP_CONFIG, 8'h0E);
    t_exc(3'b100, 8'h40, 4'h0);
    rd(ADDR_AMP_AVG_DISPLAY, d);
    check(d, 8'h02);
    $display("measure done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {i_srst, i_wr, i_rd, i_wakeup_mode, i_set_default, i_cal_done, i_cal_error} = 7'h40;
    {i_addr, i_wdata, i_amp_result, aux, pc_cfg, i_meas_done, i_cal_value} = '0;
    repeat (10) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_regs();
    t_status();
    t_timer(8'hAC, 30);
    t_timer(8'h0F, 40);
    t_meas();
    end_sim();
  end
  initial begin
    #(5000 * 100);
    err_total++;
    end_sim();
  end
endmodule

//--- src/delta_average_unit.sv
// one measurement channel: reference compare and running average
// assumes result and valid come from measurement logic on the same clock
`timescale 1ns/1ns
module delta_average_unit (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_clear,
  // measurement result
  input wire logic i_valid,
  input wire logic [7:0] i_result,
  // settings
  input wire logic [7:0] i_config,
  input wire logic [7:0] i_reference,
  // outcome
  output logic o_excursion,
  output logic [7:0] o_average
);
  import wut_pkg::*;

  logic [7:0] compare_ref;
  logic [7:0] abs_diff;
  logic exceeds;
  logic [3:0] threshold;
  logic [2:0] shift;
  logic signed [8:0] avg_delta;
  logic signed [8:0] avg_step;
  logic update_avg;

  assign threshold = i_config[CFG_DELTA_LSB +: 4];
  assign compare_ref = i_config[CFG_REFSEL_BIT] ? o_average : i_reference;
  assign abs_diff = (i_result >= compare_ref) ? (i_result - compare_ref)
                                              : (compare_ref - i_result);
  assign exceeds = abs_diff > {4'h0, threshold};

  // weight 4, 8, 16 or 32 as a right shift of 2 to 5
  assign shift = WEIGHT_SHIFT_MIN + {1'b0, i_config[CFG_WEIGHT_LSB +: 2]};
  assign avg_delta = $signed({1'b0, i_result}) - $signed({1'b0, o_average});
  assign avg_step = avg_delta >>> shift;
  assign update_avg = i_valid && (!exceeds || i_config[CFG_INCLUDE_BIT]);

  // excursion pulse one cycle after the result
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_excursion <= 1'b0;
    end else begin
      o_excursion <= i_valid && exceeds;
    end
  end

  // running average
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_clear) begin
      o_average <= REG_RESET;
    end else if (update_avg) begin
      o_average <= o_average + avg_step[7:0];
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  a_excursion_strict: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_valid && (abs_diff <= {4'h0, threshold}) |=> !o_excursion)
    else $error("excursion flagged within threshold");

  a_excluded_holds_avg: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_valid && exceeds && !i_config[CFG_INCLUDE_BIT] && !i_clear |=> $stable(o_average))
    else $error("excluded measurement changed average");

endmodule

//--- src/wakeup_period_timer.sv
// wake-up period timer: base tick prescaler and timeout code counter
// assumes control inputs come from logic on the same clock
`timescale 1ns/1ns
module wakeup_period_timer #(
  parameter int LONG_CYCLES = wut_pkg::LONG_BASE_CYCLES,
  parameter int SHORT_CYCLES = wut_pkg::SHORT_BASE_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // control
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic i_short_range,
  input wire logic [2:0] i_code,
  // expiry pulse
  output logic o_expire
);
  import wut_pkg::*;

  logic [TIMER_CNT_W-1:0] tick_cnt_reg;
  logic [2:0] period_cnt_reg;
  logic [TIMER_CNT_W-1:0] base_last;
  logic base_tick;

  // last count of one base period for the selected range
  always_comb begin
    if (i_short_range) begin
      base_last = TIMER_CNT_W'(SHORT_CYCLES - 1);
    end else begin
      base_last = TIMER_CNT_W'(LONG_CYCLES - 1);
    end
  end

  assign base_tick = (tick_cnt_reg >= base_last);

  // base period prescaler, restarted on stop or reprogramming
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_run || i_restart || base_tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // counts base periods up to code plus one
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_run || i_restart) begin
      period_cnt_reg <= 3'h0;
    end else if (base_tick) begin
      if (period_cnt_reg >= i_code) begin
        period_cnt_reg <= 3'h0;
      end else begin
        period_cnt_reg <= period_cnt_reg + 3'h1;
      end
    end
  end

  // one-cycle expiry pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_expire <= 1'b0;
    end else begin
      o_expire <= i_run && !i_restart && base_tick && (period_cnt_reg >= i_code);
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  a_expire_needs_run: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_expire |-> $past(i_run)) else $error("expiry while timer stopped");

  a_period_in_range: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !$past(i_restart) && $stable(i_code) |-> period_cnt_reg <= i_code)
    else $error("period count beyond timeout code");

endmodule

//--- src/wakeup_timer_measure_regs.sv
// wake-up timer, periodic measurement trigger and status display registers
// assumes measurement engines and cal logic share i_sys_clk; status pins do not
`timescale 1ns/1ns
module wakeup_timer_measure_regs #(
  parameter int LONG_BASE_CYCLES_P = wut_pkg::LONG_BASE_CYCLES,
  parameter int SHORT_BASE_CYCLES_P = wut_pkg::SHORT_BASE_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // register port
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // mode control
  input wire logic i_wakeup_mode,
  input wire logic i_set_default,
  // measurement engines
  output logic [wut_pkg::N_MEAS-1:0] o_meas_start,
  input wire logic [wut_pkg::N_MEAS-1:0] i_meas_done,
  input wire logic [7:0] i_amp_result,
  input wire logic [7:0] i_phase_result,
  input wire logic [7:0] i_cap_result,
  // phase and capacitance settings held elsewhere
  input wire logic [7:0] i_phase_config,
  input wire logic [7:0] i_phase_reference,
  input wire logic [7:0] i_cap_config,
  input wire logic [7:0] i_cap_reference,
  // interrupt events
  output logic o_timeout_irq,
  output logic [wut_pkg::N_MEAS-1:0] o_excursion_irq,
  output logic o_wakeup_irq,
  // capacitive sensor calibration
  input wire logic i_cal_done,
  input wire logic i_cal_error,
  input wire logic [4:0] i_cal_value,
  // auxiliary status pins
  input wire logic i_rx_channel_pm,
  input wire logic i_field_detected,
  input wire logic i_tx_active,
  input wire logic i_osc_stable,
  input wire logic i_rx_enabled,
  input wire logic i_rx_receiving,
  input wire logic i_field_detect_peer,
  input wire logic i_field_detect_collision_avoid
);
  import wut_pkg::*;

  // ******************************************************************
  // declarations
  // ******************************************************************
  logic [7:0] timer_ctrl_reg;
  logic [7:0] amp_config_reg;
  logic [7:0] amp_reference_reg;
  logic [7:0] capsense_display_reg;
  logic [7:0] aux_display_reg;
  logic [7:0] amp_result_reg;
  logic [7:0] aux_meta_reg;
  logic [7:0] aux_sync_reg;
  logic [7:0] aux_pins;
  logic [7:0] rdata_next;
  logic [N_MEAS-1:0] meas_enable;
  logic [N_MEAS-1:0] excursion;
  logic [7:0] result_arr [N_MEAS];
  logic [7:0] config_arr [N_MEAS];
  logic [7:0] reference_arr [N_MEAS];
  logic [7:0] average_arr [N_MEAS];
  logic timer_expire;
  logic ctrl_write;
  logic defaults;

  assign defaults = i_set_default;
  assign ctrl_write = i_wr && (i_addr == ADDR_TIMER_CTRL);

  // ******************************************************************
  // software registers
  // ******************************************************************

  // timer control register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults) begin
      timer_ctrl_reg <= REG_RESET;
    end else if (ctrl_write) begin
      timer_ctrl_reg <= i_wdata;
    end
  end

  // amplitude measurement configuration register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults) begin
      amp_config_reg <= REG_RESET;
    end else if (i_wr && (i_addr == ADDR_AMP_CONFIG)) begin
      amp_config_reg <= i_wdata;
    end
  end

  // amplitude reference register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults) begin
      amp_reference_reg <= REG_RESET;
    end else if (i_wr && (i_addr == ADDR_AMP_REFERENCE)) begin
      amp_reference_reg <= i_wdata;
    end
  end

  // ******************************************************************
  // wake-up timer
  // ******************************************************************

  // runs only in wake-up mode; a control write restarts the period
  wakeup_period_timer #(
    .LONG_CYCLES(LONG_BASE_CYCLES_P),
    .SHORT_CYCLES(SHORT_BASE_CYCLES_P)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst || defaults),
    .i_run(i_wakeup_mode),
    .i_restart(ctrl_write),
    .i_short_range(timer_ctrl_reg[CTRL_RANGE_BIT]),
    .i_code(timer_ctrl_reg[CTRL_CODE_LSB +: 3]),
    .o_expire(timer_expire)
  );

  assign meas_enable[MEAS_AMP] = timer_ctrl_reg[CTRL_AMP_BIT];
  assign meas_enable[MEAS_PHASE] = timer_ctrl_reg[CTRL_PHASE_BIT];
  assign meas_enable[MEAS_CAP] = timer_ctrl_reg[CTRL_CAP_BIT];

  // measurement start pulses at each expiry
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_meas_start <= '0;
    end else begin
      o_meas_start <= timer_expire ? meas_enable : '0;
    end
  end

  // ******************************************************************
  // measurement compare and averaging
  // ******************************************************************
  assign result_arr[MEAS_AMP] = i_amp_result;
  assign result_arr[MEAS_PHASE] = i_phase_result;
  assign result_arr[MEAS_CAP] = i_cap_result;
  assign config_arr[MEAS_AMP] = amp_config_reg;
  assign config_arr[MEAS_PHASE] = i_phase_config;
  assign config_arr[MEAS_CAP] = i_cap_config;
  assign reference_arr[MEAS_AMP] = amp_reference_reg;
  assign reference_arr[MEAS_PHASE] = i_phase_reference;
  assign reference_arr[MEAS_CAP] = i_cap_reference;

  // one compare and average unit per measurement kind
  for (genvar g = 0; g < N_MEAS; g++) begin : g_meas
    delta_average_unit u_delta (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_clear(defaults),
      .i_valid(i_meas_done[g]),
      .i_result(result_arr[g]),
      .i_config(config_arr[g]),
      .i_reference(reference_arr[g]),
      .o_excursion(excursion[g]),
      .o_average(average_arr[g])
    );
  end

  // last amplitude result for display
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults) begin
      amp_result_reg <= REG_RESET;
    end else if (i_meas_done[MEAS_AMP]) begin
      amp_result_reg <= i_amp_result;
    end
  end

  // ******************************************************************
  // interrupt events
  // ******************************************************************

  // timeout event when every-timeout irq is enabled
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_timeout_irq <= 1'b0;
    end else begin
      o_timeout_irq <= timer_expire && timer_ctrl_reg[CTRL_IRQ_EVERY_BIT];
    end
  end

  // excursion events, only for measurements enabled in the timer control register, in any mode
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_excursion_irq <= '0;
    end else begin
      o_excursion_irq <= excursion & meas_enable;
    end
  end

  // combined interrupt pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_wakeup_irq <= 1'b0;
    end else begin
      o_wakeup_irq <= (timer_expire && timer_ctrl_reg[CTRL_IRQ_EVERY_BIT])
                      || (|(excursion & meas_enable));
    end
  end

  // ******************************************************************
  // status displays
  // ******************************************************************

  // capacitive sensor calibration display; completion wins over defaults
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      capsense_display_reg <= REG_RESET;
    end else if (i_cal_done) begin
      capsense_display_reg[CAL_VALUE_LSB +: 5] <= i_cal_value;
      capsense_display_reg[CAL_END_BIT] <= 1'b1;
      capsense_display_reg[CAL_ERR_BIT] <= i_cal_error;
      capsense_display_reg[0] <= 1'b0;
    end else if (defaults) begin
      capsense_display_reg <= REG_RESET;
    end
  end

  // status pins in display bit order
  assign aux_pins = {i_rx_channel_pm, i_field_detected, i_tx_active, i_osc_stable,
                     i_rx_enabled, i_rx_receiving, i_field_detect_peer,
                     i_field_detect_collision_avoid};

  // two-stage synchroniser for the status pins
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      aux_meta_reg <= REG_RESET;
      aux_sync_reg <= REG_RESET;
    end else begin
      aux_meta_reg <= aux_pins;
      aux_sync_reg <= aux_meta_reg;
    end
  end

  // auxiliary display follows the synchronised pins
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults) begin
      aux_display_reg <= REG_RESET;
    end else begin
      aux_display_reg <= aux_sync_reg;
    end
  end

  // ******************************************************************
  // read path
  // ******************************************************************

  // read mux, unmapped addresses read zero
  always_comb begin
    unique case (i_addr)
      ADDR_CAPSENSE_DISPLAY: rdata_next = capsense_display_reg;
      ADDR_AUX_DISPLAY: rdata_next = aux_display_reg;
      ADDR_TIMER_CTRL: rdata_next = timer_ctrl_reg;
      ADDR_AMP_CONFIG: rdata_next = amp_config_reg;
      ADDR_AMP_REFERENCE: rdata_next = amp_reference_reg;
      ADDR_AMP_AVG_DISPLAY: rdata_next = average_arr[MEAS_AMP];
      ADDR_AMP_RESULT_DISPLAY: rdata_next = amp_result_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  a_timeout_irq_follows: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    timer_expire && timer_ctrl_reg[CTRL_IRQ_EVERY_BIT] |=> o_timeout_irq && o_wakeup_irq)
    else $error("timeout irq missing");

  a_no_irq_disabled: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_timeout_irq |-> $past(timer_ctrl_reg[CTRL_IRQ_EVERY_BIT]) && $past(timer_expire))
    else $error("timeout irq without cause");

  a_amp_start_pulse: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    timer_expire |=> o_meas_start[MEAS_AMP] == $past(timer_ctrl_reg[CTRL_AMP_BIT]))
    else $error("amplitude start does not match enable");

  a_phase_start_pulse: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_meas_start[MEAS_PHASE] |-> $past(timer_expire) && $past(meas_enable[MEAS_PHASE]))
    else $error("phase start without expiry");

  a_cap_excursion_gated: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    excursion[MEAS_CAP] && !meas_enable[MEAS_CAP] |=> !o_excursion_irq[MEAS_CAP])
    else $error("cap excursion irq while disabled");

  a_reference_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_wr && (i_addr == ADDR_AMP_REFERENCE) && !defaults |=> amp_reference_reg == $past(i_wdata))
    else $error("reference write lost");

  a_defaults_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    defaults |=> timer_ctrl_reg == 8'h00 && amp_config_reg == 8'h00 && aux_display_reg == 8'h00)
    else $error("defaults not restored");

  a_cal_end_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_cal_done |=> capsense_display_reg[CAL_END_BIT]
      && capsense_display_reg[CAL_VALUE_LSB +: 5] == $past(i_cal_value))
    else $error("calibration result not shown");

  a_aux_pin_latency: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !defaults && !$past(defaults) && !$past(i_srst, 3)
      |-> aux_display_reg == $past(aux_pins, 3))
    else $error("aux display not three cycles behind pins");

  a_read_only_after: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");

endmodule

//--- src/wut_pkg.sv
// constants shared by the wake-up timer and measurement register block
// assumes a 10 MHz system clock and byte-wide registers on a 6-bit address
package wut_pkg;

  // ******************************************************************
  // register addresses
  // ******************************************************************
  localparam logic [5:0] ADDR_CAPSENSE_DISPLAY = 6'h2F;
  localparam logic [5:0] ADDR_AUX_DISPLAY = 6'h30;
  localparam logic [5:0] ADDR_TIMER_CTRL = 6'h31;
  localparam logic [5:0] ADDR_AMP_CONFIG = 6'h32;
  localparam logic [5:0] ADDR_AMP_REFERENCE = 6'h33;
  localparam logic [5:0] ADDR_AMP_AVG_DISPLAY = 6'h34;
  localparam logic [5:0] ADDR_AMP_RESULT_DISPLAY = 6'h35;

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;

  // ******************************************************************
  // timer control fields
  // ******************************************************************
  localparam int CTRL_RANGE_BIT = 7;
  localparam int CTRL_CODE_LSB = 4;
  localparam int CTRL_IRQ_EVERY_BIT = 3;
  localparam int CTRL_AMP_BIT = 2;
  localparam int CTRL_PHASE_BIT = 1;
  localparam int CTRL_CAP_BIT = 0;

  // ******************************************************************
  // measurement configuration fields
  // ******************************************************************
  localparam int CFG_DELTA_LSB = 4;
  localparam int CFG_INCLUDE_BIT = 3;
  localparam int CFG_WEIGHT_LSB = 1;
  localparam int CFG_REFSEL_BIT = 0;
  localparam logic [2:0] WEIGHT_SHIFT_MIN = 3'h2;

  // ******************************************************************
  // capacitive sensor display fields
  // ******************************************************************
  localparam int CAL_VALUE_LSB = 3;
  localparam int CAL_END_BIT = 2;
  localparam int CAL_ERR_BIT = 1;
  localparam int CAL_STEP_FF = 100;
  localparam int CAL_MAX_FF = 3100;

  // ******************************************************************
  // measurement channels
  // ******************************************************************
  localparam int MEAS_CAP = 0;
  localparam int MEAS_PHASE = 1;
  localparam int MEAS_AMP = 2;
  localparam int N_MEAS = 3;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int LONG_BASE_MS = 100;
  localparam int SHORT_BASE_MS = 10;
  localparam int LONG_BASE_CYCLES = CLK_FREQ_HZ / 1000 * LONG_BASE_MS;
  localparam int SHORT_BASE_CYCLES = CLK_FREQ_HZ / 1000 * SHORT_BASE_MS;
  localparam int TIMER_CNT_W = 20;

endpackage
